/* logic/ldseq_pkg.sv */
// Shared types and constants for the load instruction bus sequencer
`default_nettype none
package ldseq_pkg;

    // ****************************************************************
    // Instruction groups handled by the sequencer
    // ****************************************************************
    typedef enum logic [3:0] {
        CLS_IDX_IMM    = 4'h0,
        CLS_A_PAIR_RD  = 4'h1,
        CLS_A_DIR_RD   = 4'h2,
        CLS_A_PAIR_WR  = 4'h3,
        CLS_A_DIR_WR   = 4'h4,
        CLS_A_SPECIAL  = 4'h5,
        CLS_PAIR_IMM16 = 4'h6,
        CLS_IDX_IMM16  = 4'h7,
        CLS_DBL_DIR_RD = 4'h8,
        CLS_RR_DIR_RD  = 4'h9,
        CLS_DBL_DIR_WR = 4'hA,
        CLS_RR_DIR_WR  = 4'hB
    } instr_class_t;

    // ****************************************************************
    // Kinds of machine cycle
    // ****************************************************************
    typedef enum logic [3:0] {
        CYC_OPC1    = 4'h0,
        CYC_OPC2    = 4'h1,
        CYC_DISP    = 4'h2,
        CYC_IMM     = 4'h3,
        CYC_ADR_LO  = 4'h4,
        CYC_ADR_HI  = 4'h5,
        CYC_IDLE    = 4'h6,
        CYC_RD_PAIR = 4'h7,
        CYC_RD_DIR  = 4'h8,
        CYC_RD_DIR1 = 4'h9,
        CYC_WR_IDX  = 4'hA,
        CYC_WR_PAIR = 4'hB,
        CYC_WR_DIR  = 4'hC,
        CYC_WR_DIR1 = 4'hD,
        CYC_DONE    = 4'hE
    } cycle_kind_t;

    typedef enum logic [0:0] {
        PH_WAIT = 1'b0,
        PH_RUN  = 1'b1
    } phase_t;

    // ****************************************************************
    // Carriers
    // ****************************************************************
    typedef struct packed {
        logic rd_n;
        logic wr_n;
        logic memory_access_request_n;
        logic port_access_request_n;
        logic fetch_cycle_marker_n;
        logic halt_n;
        logic opcode_begin_flag_n;
    } bus_ctrl_t;

    typedef struct packed {
        instr_class_t cls;
        logic [15:0]  pc;
        logic [15:0]  pair_addr;
        logic [15:0]  index_base;
        logic [15:0]  store_word;
    } instr_req_t;

    // ****************************************************************
    // Constants
    // ****************************************************************
    localparam bus_ctrl_t   BUS_QUIET  = 7'h7F;
    localparam logic [1:0]  T_FIRST    = 2'h0;
    localparam logic [1:0]  T_LAST     = 2'h2;
    localparam logic [2:0]  STEP_RESET = 3'h0;
    localparam logic [15:0] ADDR_RESET = 16'h0000;
    localparam logic [7:0]  BYTE_RESET = 8'h00;
    localparam logic [15:0] PC_STEP    = 16'h0001;

    // ****************************************************************
    // Cycle table
    // ****************************************************************
    function automatic cycle_kind_t cyc_of(input instr_class_t c,
                                           input logic [2:0] s);
        cycle_kind_t k;
        k = CYC_DONE;
        if (s == 3'h0) begin
            k = CYC_OPC1;
        end else begin
            unique case (c)
                CLS_IDX_IMM: begin
                    case (s)
                        3'h1:    k = CYC_OPC2;
                        3'h2:    k = CYC_DISP;
                        3'h3:    k = CYC_IMM;
                        3'h4:    k = CYC_WR_IDX;
                        default: k = CYC_DONE;
                    endcase
                end
                CLS_A_PAIR_RD: k = (s == 3'h1) ? CYC_RD_PAIR : CYC_DONE;
                CLS_A_PAIR_WR: begin
                    case (s)
                        3'h1:    k = CYC_IDLE;
                        3'h2:    k = CYC_WR_PAIR;
                        default: k = CYC_DONE;
                    endcase
                end
                CLS_A_SPECIAL: k = (s == 3'h1) ? CYC_OPC2 : CYC_DONE;
                CLS_A_DIR_RD, CLS_A_DIR_WR, CLS_PAIR_IMM16,
                CLS_DBL_DIR_RD, CLS_DBL_DIR_WR: begin
                    case (s)
                        3'h1: k = CYC_ADR_LO;
                        3'h2: k = CYC_ADR_HI;
                        3'h3: begin
                            if (c == CLS_A_DIR_RD) k = CYC_RD_DIR;
                            else if (c == CLS_DBL_DIR_RD) k = CYC_RD_DIR;
                            else if (c == CLS_PAIR_IMM16) k = CYC_DONE;
                            else k = CYC_IDLE;
                        end
                        3'h4: begin
                            if (c == CLS_DBL_DIR_RD) k = CYC_RD_DIR1;
                            else if (c == CLS_DBL_DIR_WR) k = CYC_WR_DIR;
                            else if (c == CLS_A_DIR_WR) k = CYC_WR_DIR;
                            else k = CYC_DONE;
                        end
                        3'h5: k = (c == CLS_DBL_DIR_WR) ? CYC_WR_DIR1
                                                        : CYC_DONE;
                        default: k = CYC_DONE;
                    endcase
                end
                CLS_IDX_IMM16, CLS_RR_DIR_RD, CLS_RR_DIR_WR: begin
                    case (s)
                        3'h1: k = CYC_OPC2;
                        3'h2: k = CYC_ADR_LO;
                        3'h3: k = CYC_ADR_HI;
                        3'h4: begin
                            if (c == CLS_RR_DIR_RD) k = CYC_RD_DIR;
                            else if (c == CLS_RR_DIR_WR) k = CYC_IDLE;
                            else k = CYC_DONE;
                        end
                        3'h5: begin
                            if (c == CLS_RR_DIR_RD) k = CYC_RD_DIR1;
                            else if (c == CLS_RR_DIR_WR) k = CYC_WR_DIR;
                            else k = CYC_DONE;
                        end
                        3'h6: begin
                            if (c == CLS_RR_DIR_WR) k = CYC_WR_DIR1;
                            else k = CYC_DONE;
                        end
                        default: k = CYC_DONE;
                    endcase
                end
                default: k = CYC_DONE;
            endcase
        end
        return k;
    endfunction

endpackage
`default_nettype wire

/* logic/byte_latch.sv */
// Operand byte holder with a same-cycle bypass view
`timescale 1ns/1ps
`default_nettype none
module byte_latch
    import ldseq_pkg::*;
#(
    parameter int WIDTH = 8
) (
    input  wire logic             sys_clk,
    input  wire logic             rstn,
    input  wire logic             clk_en,
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q,
    output logic      [WIDTH-1:0] view
);

    logic [WIDTH-1:0] next_q;

    always_comb begin
        next_q = load ? d : q;
    end

    // Lets the sequencer form an address from a byte still on the bus
    assign view = next_q;

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            q <= '0;
        end else if (clk_en) begin
            q <= next_q;
        end
    end

endmodule
`default_nettype wire

/* logic/load_instr_bus_cycle_sequencer.sv */
// Bus machine cycle sequencer for 8 and 16 bit load instructions
`timescale 1ns/1ps
`default_nettype none
module load_instr_bus_cycle_sequencer
    import ldseq_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    input  wire logic        clk_en,
    input  wire logic        req_valid,
    input  wire instr_req_t  req_in,
    input  wire logic [7:0]  data_in,
    output bus_ctrl_t        bus,
    output logic [15:0]      addr,
    output logic [7:0]       data_out,
    output logic             data_oe,
    output logic             busy,
    output logic             instr_done,
    output logic             irq_sample
);

    // ****************************************************************
    // State
    // ****************************************************************
    phase_t      phase, next_phase;
    logic [2:0]  step, next_step;
    logic [1:0]  tph, next_tph;
    instr_req_t  req, next_req;
    logic [15:0] pc, next_pc;
    cycle_kind_t kind, nk;
    bus_ctrl_t   next_bus;
    logic [15:0] next_addr;
    logic [7:0]  next_data_out;
    logic        next_data_oe, next_busy, next_done, next_irq;
    logic        cycle_end, bus_last;
    logic        ld_disp, ld_imm, ld_lo, ld_hi;
    logic [7:0]  disp_q, imm_q, lo_q, hi_q;
    logic [7:0]  disp_v, imm_v, lo_v, hi_v;
    logic [15:0] dir_addr;

    assign kind     = (phase == PH_RUN) ? cyc_of(req.cls, step) : CYC_DONE;
    assign bus_last = (phase == PH_RUN) && (tph == T_LAST);
    // Operand bytes are caught at the end of their T3
    assign ld_disp  = bus_last && (kind == CYC_DISP);
    assign ld_imm   = bus_last && (kind == CYC_IMM);
    assign ld_lo    = bus_last && (kind == CYC_ADR_LO);
    assign ld_hi    = bus_last && (kind == CYC_ADR_HI);
    assign dir_addr = {hi_v, lo_v};

    byte_latch #(.WIDTH(8)) u_disp (.sys_clk(sys_clk), .rstn(rstn),
        .clk_en(clk_en), .load(ld_disp), .d(data_in), .q(disp_q),
        .view(disp_v));
    byte_latch #(.WIDTH(8)) u_imm (.sys_clk(sys_clk), .rstn(rstn),
        .clk_en(clk_en), .load(ld_imm), .d(data_in), .q(imm_q),
        .view(imm_v));
    byte_latch #(.WIDTH(8)) u_lo (.sys_clk(sys_clk), .rstn(rstn),
        .clk_en(clk_en), .load(ld_lo), .d(data_in), .q(lo_q),
        .view(lo_v));
    byte_latch #(.WIDTH(8)) u_hi (.sys_clk(sys_clk), .rstn(rstn),
        .clk_en(clk_en), .load(ld_hi), .d(data_in), .q(hi_q),
        .view(hi_v));

    // ****************************************************************
    // Sequencing and bus decode
    // ****************************************************************
    always_comb begin
        next_phase = phase;
        next_step  = step;
        next_tph   = tph;
        next_req   = req;
        next_pc    = pc;
        next_done  = 1'b0;
        next_irq   = 1'b0;
        // Idle states last one clock, bus cycles three
        cycle_end  = (phase == PH_RUN) && ((kind == CYC_IDLE) || bus_last);
        unique case (phase)
            PH_WAIT: begin
                if (req_valid) begin
                    next_req   = req_in;
                    next_pc    = req_in.pc;
                    next_step  = STEP_RESET;
                    next_tph   = T_FIRST;
                    next_phase = PH_RUN;
                end
            end
            PH_RUN: begin
                if (cycle_end) begin
                    next_step = step + 3'h1;
                    next_tph  = T_FIRST;
                    if (kind <= CYC_ADR_HI) begin
                        next_pc = pc + PC_STEP;
                    end
                    if (cyc_of(req.cls, next_step) == CYC_DONE) begin
                        next_phase = PH_WAIT;
                        next_done  = 1'b1;
                        // No sampling after special moves
                        next_irq   = (req.cls != CLS_A_SPECIAL);
                    end
                end else begin
                    next_tph = tph + 2'h1;
                end
            end
        endcase
        next_busy = (next_phase == PH_RUN);
        // Outputs decode the cycle about to run so they stay registered
        nk = (next_phase == PH_RUN) ? cyc_of(next_req.cls, next_step)
                                    : CYC_DONE;
        next_bus      = BUS_QUIET;
        next_addr     = ADDR_RESET;
        next_data_out = BYTE_RESET;
        next_data_oe  = 1'b0;
        unique case (nk)
            CYC_OPC1: begin
                next_bus.rd_n                    = 1'b0;
                next_bus.memory_access_request_n = 1'b0;
                next_bus.fetch_cycle_marker_n    = 1'b0;
                next_bus.opcode_begin_flag_n     = 1'b0;
                next_addr                        = next_pc;
            end
            CYC_OPC2: begin
                next_bus.rd_n                    = 1'b0;
                next_bus.memory_access_request_n = 1'b0;
                next_bus.fetch_cycle_marker_n    = 1'b0;
                next_addr                        = next_pc;
            end
            CYC_DISP, CYC_IMM, CYC_ADR_LO, CYC_ADR_HI: begin
                next_bus.rd_n                    = 1'b0;
                next_bus.memory_access_request_n = 1'b0;
                next_addr                        = next_pc;
            end
            CYC_RD_PAIR, CYC_RD_DIR, CYC_RD_DIR1: begin
                next_bus.rd_n                    = 1'b0;
                next_bus.memory_access_request_n = 1'b0;
                if (nk == CYC_RD_PAIR) next_addr = next_req.pair_addr;
                else if (nk == CYC_RD_DIR) next_addr = dir_addr;
                else next_addr = dir_addr + PC_STEP;
            end
            CYC_WR_IDX, CYC_WR_PAIR, CYC_WR_DIR, CYC_WR_DIR1: begin
                next_bus.wr_n                    = 1'b0;
                next_bus.memory_access_request_n = 1'b0;
                next_data_oe                     = 1'b1;
                next_data_out = next_req.store_word[7:0];
                if (nk == CYC_WR_IDX) begin
                    // Signed displacement
                    next_addr     = next_req.index_base
                                  + {{8{disp_v[7]}}, disp_v};
                    next_data_out = imm_v;
                end else if (nk == CYC_WR_PAIR) begin
                    next_addr = next_req.pair_addr;
                end else if (nk == CYC_WR_DIR) begin
                    next_addr = dir_addr;
                end else begin
                    next_addr     = dir_addr + PC_STEP;
                    next_data_out = next_req.store_word[15:8];
                end
            end
            CYC_IDLE, CYC_DONE: begin
                next_bus = BUS_QUIET;
            end
            default: next_bus = BUS_QUIET;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            phase      <= PH_WAIT;
            step       <= STEP_RESET;
            tph        <= T_FIRST;
            req        <= '0;
            pc         <= ADDR_RESET;
            bus        <= BUS_QUIET;
            addr       <= ADDR_RESET;
            data_out   <= BYTE_RESET;
            data_oe    <= 1'b0;
            busy       <= 1'b0;
            instr_done <= 1'b0;
            irq_sample <= 1'b0;
        end else if (clk_en) begin
            phase      <= next_phase;
            step       <= next_step;
            tph        <= next_tph;
            req        <= next_req;
            pc         <= next_pc;
            bus        <= next_bus;
            addr       <= next_addr;
            data_out   <= next_data_out;
            data_oe    <= next_data_oe;
            busy       <= next_busy;
            instr_done <= next_done;
            irq_sample <= next_irq;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);

    sequence s_mem_write;
        !bus.wr_n && bus.rd_n && !bus.memory_access_request_n && data_oe;
    endsequence
    sequence s_quiet;
        bus == BUS_QUIET && !data_oe;
    endsequence

    a_first_fetch: assert property (clk_en && $rose(busy) |->
        !bus.rd_n && !bus.memory_access_request_n
        && !bus.fetch_cycle_marker_n && !bus.opcode_begin_flag_n
        && addr == req.pc)
        else $error("first cycle is not an opcode fetch");
    a_second_opcode: assert property (kind == CYC_OPC2 |->
        !bus.fetch_cycle_marker_n && bus.opcode_begin_flag_n && !bus.rd_n)
        else $error("second opcode fetch strobes wrong");
    a_operand_read: assert property ((kind == CYC_DISP
        || kind == CYC_ADR_LO || kind == CYC_ADR_HI) && tph == T_FIRST
        |-> bus.fetch_cycle_marker_n && bus.opcode_begin_flag_n
        && !bus.rd_n && addr == pc)
        else $error("operand fetch not from instruction address");
    a_idx_store: assert property (busy && req.cls == CLS_IDX_IMM
        && step == 3'h4 |-> s_mem_write and (addr == req.index_base
        + {{8{disp_q[7]}}, disp_q}) and (data_out == imm_q))
        else $error("indexed store wrong in fifth cycle");
    a_idle_single: assert property (kind == CYC_IDLE && clk_en
        |-> s_quiet ##1 kind != CYC_IDLE)
        else $error("idle state not single and quiet");
    a_dir_store: assert property (busy
        && req.cls == CLS_A_DIR_WR && step == 3'h3 && clk_en
        |-> s_quiet ##1 (s_mem_write and addr == {hi_q, lo_q}
        && data_out == req.store_word[7:0]))
        else $error("direct accumulator store sequence wrong");
    a_special_irq: assert property (instr_done
        && req.cls == CLS_A_SPECIAL |-> !irq_sample && step == 3'h2)
        else $error("special move sampled interrupt or wrong length");
    a_idx16_len: assert property (instr_done
        && req.cls == CLS_IDX_IMM16 |-> step == 3'h4)
        else $error("index immediate load not four cycles");
    a_dbl_read: assert property (kind == CYC_RD_DIR1
        |-> addr == {hi_q, lo_q} + PC_STEP && !bus.rd_n)
        else $error("second direct read not at next address");
    a_rr_len: assert property (instr_done
        && req.cls == CLS_RR_DIR_RD |-> step == 3'h6)
        else $error("two-opcode direct load not six cycles");
    a_dbl_store: assert property (instr_done
        && req.cls == CLS_DBL_DIR_WR |-> step == 3'h6)
        else $error("direct pair store not six cycles");
    a_rr_store: assert property (instr_done
        && req.cls == CLS_RR_DIR_WR |-> step == 3'h7)
        else $error("two-opcode direct store not seven cycles");
    a_no_port: assert property (bus.port_access_request_n
        && bus.halt_n && (bus.rd_n && bus.wr_n
        || !bus.memory_access_request_n))
        else $error("port request or halt driven active");

endmodule
`default_nettype wire

/* tb/mem_model.sv */
// Memory device model answering the sequencer's bus reads
`timescale 1ns/1ps
`default_nettype none
module mem_model
    import ldseq_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire bus_ctrl_t   bus,
    input  wire logic [15:0] addr,
    output logic      [7:0]  data_in
);
    logic [7:0] churn = 8'h00;

    always_ff @(posedge sys_clk) begin
        churn <= churn + 8'h3B;
    end

    // ****************************************************************
    // Read answer
    // ****************************************************************
    always_comb begin
        if (!bus.rd_n && !bus.memory_access_request_n) begin
            data_in = addr[7:0] ^ addr[15:8] ^ 8'h5A;
        end else begin
            // Released bus keeps moving so stale bytes cannot pass
            data_in = ~churn;
        end
    end
endmodule
`default_nettype wire

/* tb/load_instr_bus_cycle_sequencer_test.sv */
// Self-checking bench for the load instruction bus cycle sequencer
`timescale 1ns/1ps
`default_nettype none
module load_instr_bus_cycle_sequencer_test
    import ldseq_pkg::*;
;
    typedef struct packed {
        logic        done;
        bus_ctrl_t   bus;
        logic [15:0] a;
        logic        oe;
        logic [7:0]  d;
        logic        irq;
    } note_t;

    localparam bus_ctrl_t B_OP1 = 7'h2A;
    localparam bus_ctrl_t B_OP2 = 7'h2B;
    localparam bus_ctrl_t B_RD  = 7'h2F;
    localparam bus_ctrl_t B_WR  = 7'h4F;

    logic        sys_clk;
    logic        rstn;
    logic        clk_en;
    logic        req_valid;
    instr_req_t  req_in;
    logic [7:0]  data_in;
    bus_ctrl_t   bus;
    logic [15:0] addr;
    logic [7:0]  data_out;
    logic        data_oe;
    logic        busy;
    logic        instr_done;
    logic        irq_sample;
    logic        en_q = 1'b1;
    logic        jitter = 1'b0;
    note_t       exp_q[$];
    note_t       n;
    int          n_fail = 0;
    int          n_checks = 0;
    int          cycles = 0;

    load_instr_bus_cycle_sequencer u_load_instr_bus_cycle_sequencer (
        .sys_clk(sys_clk), .rstn(rstn), .clk_en(clk_en),
        .req_valid(req_valid), .req_in(req_in), .data_in(data_in),
        .bus(bus), .addr(addr), .data_out(data_out), .data_oe(data_oe),
        .busy(busy), .instr_done(instr_done), .irq_sample(irq_sample)
    );

    mem_model u_mem_model (
        .sys_clk(sys_clk), .bus(bus), .addr(addr), .data_in(data_in)
    );

    always #10 sys_clk = ~sys_clk;

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    function automatic logic [7:0] mem_byte(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h5A;
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] want);
        n_checks++;
        if (seen !== want) begin
            n_fail++;
            $display("[FAIL] %0t ns: saw %h, expected %h", $time, seen, want);
        end
    endtask

    task automatic conclude();
        $display("checks %0d, mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    task automatic put(input bus_ctrl_t c, input logic [15:0] a,
                       input logic oe, input logic [7:0] d, input int k);
        repeat (k) exp_q.push_back({1'b0, c, a, oe, d, 1'b0});
    endtask

    task automatic op(inout logic [15:0] p, input bus_ctrl_t c);
        put(c, p, 1'b0, 8'h00, 3);
        p = p + 16'h0001;
    endtask

    // Expected clock-by-clock bus picture of one instruction
    task automatic plan(input instr_req_t r);
        logic [15:0] p;
        logic [15:0] mn;
        logic [7:0]  b;
        p = r.pc;
        op(p, B_OP1);
        if (r.cls inside {CLS_IDX_IMM, CLS_A_SPECIAL, CLS_IDX_IMM16,
                          CLS_RR_DIR_RD, CLS_RR_DIR_WR})
            op(p, B_OP2);
        mn = {mem_byte(p + 16'h0001), mem_byte(p)};
        case (r.cls)
            CLS_IDX_IMM: begin
                b = mem_byte(p);
                op(p, B_RD);
                mn = r.index_base + {{8{b[7]}}, b};
                b = mem_byte(p);
                op(p, B_RD);
                put(B_WR, mn, 1'b1, b, 3);
            end
            CLS_A_PAIR_RD: put(B_RD, r.pair_addr, 1'b0, 8'h00, 3);
            CLS_A_PAIR_WR: begin
                put(BUS_QUIET, 16'h0000, 1'b0, 8'h00, 1);
                put(B_WR, r.pair_addr, 1'b1, r.store_word[7:0], 3);
            end
            CLS_A_SPECIAL: ;
            default: begin
                if (r.cls <= CLS_RR_DIR_WR) begin
                    op(p, B_RD);
                    op(p, B_RD);
                end
            end
        endcase
        case (r.cls)
            CLS_A_DIR_RD: put(B_RD, mn, 1'b0, 8'h00, 3);
            CLS_A_DIR_WR: begin
                put(BUS_QUIET, 16'h0000, 1'b0, 8'h00, 1);
                put(B_WR, mn, 1'b1, r.store_word[7:0], 3);
            end
            CLS_DBL_DIR_RD, CLS_RR_DIR_RD: begin
                put(B_RD, mn, 1'b0, 8'h00, 3);
                put(B_RD, mn + 16'h0001, 1'b0, 8'h00,
                    3);
            end
            CLS_DBL_DIR_WR, CLS_RR_DIR_WR: begin
                put(BUS_QUIET, 16'h0000, 1'b0, 8'h00,
                    1);
                put(B_WR, mn, 1'b1, r.store_word[7:0], 3);
                put(B_WR, mn + 16'h0001, 1'b1, r.store_word[15:8],
                    3);
            end
            default: ;
        endcase
        exp_q.push_back({1'b1, BUS_QUIET, 16'h0000, 1'b0, 8'h00,
                         r.cls != CLS_A_SPECIAL});
    endtask

    // Holds the request up until the block has taken it
    task automatic issue(input instr_req_t r);
        logic free;
        free = 1'b0;
        plan(r);
        @(posedge sys_clk);
        req_in <= r;
        req_valid <= 1'b1;
        repeat (300) begin
            @(negedge sys_clk);
            if (free && busy === 1'b1)
                break;
            free = (busy === 1'b0);
        end
    endtask

    function automatic instr_req_t rand_req(input int c);
        instr_req_t r;
        r.cls = instr_class_t'(c[3:0]);
        r.pc = 16'($urandom);
        r.pair_addr = 16'($urandom);
        r.index_base = 16'($urandom);
        r.store_word = 16'($urandom);
        return r;
    endfunction

    // ****************************************************************
    // Output watcher
    // ****************************************************************
    always @(posedge sys_clk) en_q = clk_en;

    always @(negedge sys_clk) begin
        if (rstn && en_q) begin
            if (busy === 1'b1 || instr_done === 1'b1) begin
                if (exp_q.size() == 0) begin
                    check(16'({busy, instr_done}), 16'h0000);
                end else begin
                    n = exp_q.pop_front();
                    check(16'(bus), 16'(n.bus));
                    check(addr, n.a);
                    check(16'(busy), 16'(!n.done));
                    check(16'(data_oe), 16'(n.oe));
                    if (n.oe)
                        check(16'(data_out), 16'(n.d));
                    check(16'(instr_done), 16'(n.done));
                    if (n.done)
                        check(16'(irq_sample), 16'(n.irq));
                end
            end else begin
                check(16'(bus), 16'(BUS_QUIET));
            end
        end
    end

    always @(posedge sys_clk)
        clk_en <= jitter ? ($urandom_range(3) != 0) : 1'b1;

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 6000) begin
            n_fail++;
            $display("[FAIL] %0t ns: run did not finish", $time);
            conclude();
        end
    end

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        sys_clk = 1'b0;
        rstn = 1'b0;
        req_valid = 1'b0;
        req_in = '0;
        void'($urandom(32'h4675));
        repeat (16) @(posedge sys_clk);
        check(16'(bus), 16'(BUS_QUIET));
        check(16'(busy), 16'h0000);
        rstn <= 1'b1;
        for (int c = 0; c < 12; c++)
            issue(rand_req(c));
        $display("test class sweep back to back finished");
        jitter = 1'b1;
        repeat (24) issue(rand_req(int'($urandom_range(15))));
        jitter = 1'b0;
        $display("test random classes with clock enable gaps finished");
        @(posedge sys_clk);
        req_valid <= 1'b0;
        repeat (400) begin
            @(negedge sys_clk);
            if (exp_q.size() == 0)
                break;
        end
        repeat (10) @(negedge sys_clk);
        check(16'(exp_q.size()), 16'h0000);
        $display("test drain and idle finished");
        conclude();
    end
endmodule
`default_nettype wire
